// File: logic/upbs_pkg.sv
// shared constants and state encodings for the ulpi bus signalling ends
package upbs_pkg;
   // reference clock and interface clock
   localparam int SYS_CLK_PERIOD_NS    = 8;
   localparam int ULPI_CLK_NOMINAL_MHZ = 60;
   // reference clock is toggled every cycle, so the bus clock is half of it
   localparam int ULPI_CLK_DIV         = 2;

   // clock synthesizer settling after power-on, least time, rounded up
   localparam int PLL_SETTLE_NS     = 1000;
   localparam int PLL_SETTLE_CYCLES =
      (PLL_SETTLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int SETTLE_W              = 8;
   localparam logic [SETTLE_W-1:0] SETTLE_LAST =
      SETTLE_W'(PLL_SETTLE_CYCLES - 1);
   localparam logic [SETTLE_W-1:0] SETTLE_RST = 8'h00;

   // data bus
   localparam int DATA_W               = 8;
   localparam logic [7:0] BUS_IDLE     = 8'h00;
   localparam int LINE_STATE_W         = 2;
   localparam logic [5:0] LP_UNUSED    = 6'h00;

   // values after reset
   localparam logic RST_PHY_DIR        = 1'h1;
   localparam logic RST_STATUS_PENDING = 1'h1;
   // link takes its first clocked edge as a turnaround, so it reads no byte
   localparam logic RST_LINK_DIR       = 1'h0;

   // transceiver states
   typedef enum logic [6:0] {
      P_PWRUP  = 7'h01,
      P_IDLE   = 7'h02,
      P_TX     = 7'h04,
      P_TURN   = 7'h08,
      P_OUT    = 7'h10,
      P_END    = 7'h20,
      P_LOWPWR = 7'h40
   } upbs_phy_st_t;

   // link states
   typedef enum logic [4:0] {
      L_IDLE  = 5'h01,
      L_TX    = 5'h02,
      L_STOP  = 5'h04,
      L_SLEEP = 5'h08,
      L_WAKE  = 5'h10
   } upbs_link_st_t;
endpackage

// File: logic/upbs_ulpi_if.sv
// ulpi bus between transceiver and link, with the data wire resolved
`timescale 1ns/1ps
interface upbs_ulpi_if;
   logic       clk;
   logic       dir;
   logic       nxt;
   logic       stp;
   logic [7:0] phyData;
   logic       phyOe;
   logic [7:0] linkData;
   logic       linkOe;
   logic [7:0] data;

   // undriven bus reads low, as the pull-downs hold it
   assign data = phyOe ? phyData : (linkOe ? linkData : 8'h00);

   modport phy (
      output clk,
      output dir,
      output nxt,
      output phyData,
      output phyOe,
      input  stp,
      input  data
   );

   modport link (
      input  clk,
      input  dir,
      input  nxt,
      input  data,
      output stp,
      output linkData,
      output linkOe
   );
endinterface

// File: logic/upbs_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module upbs_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // level in and out
   input  wire logic d,
   output logic      q
);
   typedef struct packed {
      logic meta;
      logic stable;
   } upbs_sync_t;

   upbs_sync_t r;
   upbs_sync_t next_r;

   always_comb begin
      next_r        = r;
      next_r.meta   = d;
      next_r.stable = r.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.stable;
endmodule

// File: logic/upbs_phy.sv
// transceiver end of the ulpi bus: clock out, bus ownership, rx and tx bytes
//
// What this block does
// - synchronous mode: everything timed by interface clock
// - low power: signals treated as asynchronous
// - transceiver drives interface clock from reference
// - clock keeps running in low power
// - link holds data low while idle
// - link starts transfers with non-zero command byte
// - one ignored turnaround cycle per direction change
// - direction low by default, listening
// - direction high only with byte to deliver
// - direction and next high: received data byte
// - direction high, next low: status or read data
// - direction held high throughout low power
// - link pulses stop after its last byte
// - stop forces transceiver to release bus
// - stop held high wakes from low power
// - next with direction low requests following byte
// - next with direction high marks valid data
// - next meaningless in low power
// - data lines fixed-direction in low power
// - direction high after power-on until clock stable
// - status byte sent after every reset
`timescale 1ns/1ps
module upbs_phy
   import upbs_pkg::*;
(
   // reference clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // bus toward the link
   upbs_ulpi_if.phy        bus,
   // received usb data, held until taken
   input  wire logic       rxValid,
   input  wire logic [7:0] rxData,
   input  wire logic       rxActive,
   output logic            rxTaken,
   // line status for status bytes
   input  wire logic [7:0] lineStatus,
   input  wire logic       statusChange,
   // register read answer
   input  wire logic       regRdValid,
   input  wire logic [7:0] regRdData,
   // bytes sent by the link
   output logic [7:0]      txByte,
   output logic            txStrobe,
   output logic            txEnd,
   // low-power control
   input  wire logic       lpReq,
   output logic            lowPower
);
   typedef struct packed {
      upbs_phy_st_t       st;
      logic               clk;
      logic               clkRun;
      logic [SETTLE_W-1:0] settle;
      logic               dir;
      logic               nxt;
      logic               dataOe;
      logic [7:0]         dataOut;
      logic               lpTarget;
      logic               statusPending;
      logic               regPending;
      logic [7:0]         regData;
      logic [7:0]         txByte;
      logic               txStrobe;
      logic               txEnd;
      logic               rxTaken;
      logic               lowPower;
   } upbs_phy_t;

   upbs_phy_t r;
   upbs_phy_t next_r;
   logic      stpSync;
   logic      step;
   logic      serve;

   // stop is re-timed for low power, the one mode where it is asynchronous
   upbs_sync stpSyncer (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .d     (bus.stp),
      .q     (stpSync)
   );

   // the bus clock falls on this edge: inputs are mid-cycle and stable
   assign step = r.clk;

   always_comb begin
      next_r          = r;
      next_r.txStrobe = 1'b0;
      next_r.txEnd    = 1'b0;
      next_r.rxTaken  = 1'b0;
      serve           = 1'b0;

      // kept running in low power too, so the link can always clock stop
      if (r.clkRun) begin
         next_r.clk = ~r.clk;
      end

      if (r.st == P_PWRUP) begin
         next_r.dir     = 1'b1;
         next_r.dataOe  = 1'b1;
         next_r.dataOut = BUS_IDLE;
         if (r.settle == SETTLE_LAST) begin
            next_r.clkRun = 1'b1;
            next_r.dataOe = 1'b0;
            next_r.st     = P_TURN;
         end else begin
            next_r.settle = r.settle + 1'b1;
         end
      end else if (step) begin
         case (r.st)
            P_IDLE: begin
               next_r.dir    = 1'b0;
               next_r.nxt    = 1'b0;
               next_r.dataOe = 1'b0;
               if (bus.data != BUS_IDLE) begin
                  next_r.txByte   = bus.data;
                  next_r.txStrobe = 1'b1;
                  next_r.st       = P_TX;
               end else if (lpReq && !bus.stp) begin
                  next_r.dir      = 1'b1;
                  next_r.lpTarget = 1'b1;
                  next_r.st       = P_TURN;
               end else if (rxActive || rxValid || r.statusPending ||
                            r.regPending) begin
                  next_r.dir      = 1'b1;
                  next_r.lpTarget = 1'b0;
                  next_r.st       = P_TURN;
               end
            end
            P_TX: begin
               if (bus.stp) begin
                  next_r.nxt   = 1'b0;
                  next_r.txEnd = 1'b1;
                  next_r.st    = P_IDLE;
               end else begin
                  // alternate cycles give the link time to fetch a byte
                  if (r.nxt) begin
                     next_r.txByte   = bus.data;
                     next_r.txStrobe = 1'b1;
                  end
                  next_r.nxt = ~r.nxt;
               end
            end
            P_TURN: begin
               next_r.nxt = 1'b0;
               if (r.lpTarget) begin
                  next_r.dataOe   = 1'b1;
                  next_r.dataOut  = {LP_UNUSED,
                                     lineStatus[LINE_STATE_W-1:0]};
                  next_r.lowPower = 1'b1;
                  next_r.st       = P_LOWPWR;
               end else begin
                  serve = 1'b1;
               end
            end
            P_OUT: begin
               if (bus.stp) begin
                  next_r.dir    = 1'b0;
                  next_r.dataOe = 1'b0;
                  next_r.nxt    = 1'b0;
                  next_r.st     = P_END;
               end else begin
                  serve = 1'b1;
               end
            end
            P_END: begin
               // turnaround cycle: neither side drives
               next_r.dataOe = 1'b0;
               next_r.st     = P_IDLE;
            end
            P_LOWPWR: begin
               next_r.dir     = 1'b1;
               next_r.nxt     = 1'b0;
               next_r.dataOut = {LP_UNUSED,
                                 lineStatus[LINE_STATE_W-1:0]};
               if (stpSync) begin
                  next_r.dir           = 1'b0;
                  next_r.dataOe        = 1'b0;
                  next_r.lowPower      = 1'b0;
                  next_r.statusPending = 1'b1;
                  next_r.st            = P_END;
               end
            end
            default: begin
               next_r.st = P_IDLE;
            end
         endcase

         if (serve) begin
            if (r.regPending) begin
               next_r.dataOe     = 1'b1;
               next_r.dataOut    = r.regData;
               next_r.nxt        = 1'b0;
               next_r.regPending = 1'b0;
               next_r.st         = P_OUT;
            end else if (rxValid) begin
               next_r.dataOe  = 1'b1;
               next_r.dataOut = rxData;
               next_r.nxt     = 1'b1;
               next_r.rxTaken = 1'b1;
               next_r.st      = P_OUT;
            end else if (rxActive || r.statusPending) begin
               next_r.dataOe        = 1'b1;
               next_r.dataOut       = lineStatus;
               next_r.nxt           = 1'b0;
               next_r.statusPending = 1'b0;
               next_r.st            = P_OUT;
            end else begin
               next_r.dir    = 1'b0;
               next_r.dataOe = 1'b0;
               next_r.nxt    = 1'b0;
               next_r.st     = P_END;
            end
         end
      end

      // a new event wins over a clear in the same cycle
      if (statusChange) begin
         next_r.statusPending = 1'b1;
      end
      if (regRdValid) begin
         next_r.regPending = 1'b1;
         next_r.regData    = regRdData;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r               <= '0;
         r.st            <= P_PWRUP;
         r.settle        <= SETTLE_RST;
         r.dir           <= RST_PHY_DIR;
         r.statusPending <= RST_STATUS_PENDING;
      end else begin
         r <= next_r;
      end
   end

   // bus side
   assign bus.clk     = r.clk;
   assign bus.dir     = r.dir;
   assign bus.nxt     = r.nxt;
   assign bus.phyData = r.dataOut;
   assign bus.phyOe   = r.dataOe;
   // user side
   assign rxTaken     = r.rxTaken;
   assign txByte      = r.txByte;
   assign txStrobe    = r.txStrobe;
   assign txEnd       = r.txEnd;
   assign lowPower    = r.lowPower;
endmodule

// File: logic/upbs_link.sv
// link end of the ulpi bus, clocked by the interface clock
`timescale 1ns/1ps
module upbs_link
   import upbs_pkg::*;
(
   // reset
   input  wire logic       rst_n,
   // bus toward the transceiver
   upbs_ulpi_if.link       bus,
   // bytes to send; first byte of a transfer is the command
   input  wire logic       txValid,
   input  wire logic [7:0] txData,
   input  wire logic       txLast,
   output logic            txTaken,
   // bytes received
   output logic [7:0]      rxByte,
   output logic            rxDataValid,
   output logic            rxStatusValid,
   // bus release and power control
   input  wire logic       abortReq,
   input  wire logic       sleepReq,
   input  wire logic       wakeReq,
   output logic            asleep
);
   typedef struct packed {
      upbs_link_st_t st;
      logic          prevDir;
      logic          stp;
      logic          dataOe;
      logic [7:0]    dataOut;
      logic          last;
      logic          txTaken;
      logic [7:0]    rxByte;
      logic          rxDataValid;
      logic          rxStatusValid;
      logic          asleep;
   } upbs_link_t;

   upbs_link_t r;
   upbs_link_t next_r;
   logic       dirSync;
   logic       turn;

   // direction is asynchronous while the transceiver sleeps
   upbs_sync dirSyncer (
      .clk   (bus.clk),
      .rst_n (rst_n),
      .d     (bus.dir),
      .q     (dirSync)
   );

   assign turn = bus.dir != r.prevDir;

   always_comb begin
      next_r               = r;
      next_r.prevDir       = bus.dir;
      next_r.txTaken       = 1'b0;
      next_r.rxDataValid   = 1'b0;
      next_r.rxStatusValid = 1'b0;

      if (bus.dir && !turn && !r.asleep) begin
         next_r.rxByte = bus.data;
         if (bus.nxt) begin
            next_r.rxDataValid = 1'b1;
         end else begin
            next_r.rxStatusValid = 1'b1;
         end
      end

      case (r.st)
         L_IDLE: begin
            next_r.stp = 1'b0;
            if (bus.dir) begin
               next_r.dataOe  = 1'b0;
               next_r.dataOut = BUS_IDLE;
               if (sleepReq && !turn) begin
                  next_r.asleep = 1'b1;
                  next_r.st     = L_SLEEP;
               end else if (abortReq && !turn) begin
                  next_r.stp = 1'b1;
               end
            end else if (turn) begin
               next_r.dataOe = 1'b0;
            end else begin
               next_r.dataOe  = 1'b1;
               next_r.dataOut = BUS_IDLE;
               if (txValid && !r.txTaken && txData != BUS_IDLE) begin
                  next_r.dataOut = txData;
                  next_r.last    = txLast;
                  next_r.txTaken = 1'b1;
                  next_r.st      = L_TX;
               end
            end
         end
         L_TX: begin
            if (bus.dir) begin
               next_r.dataOe  = 1'b0;
               next_r.dataOut = BUS_IDLE;
               next_r.st      = L_IDLE;
            end else if (r.last) begin
               next_r.stp     = 1'b1;
               next_r.dataOut = BUS_IDLE;
               next_r.st      = L_STOP;
            end else if (bus.nxt && !r.txTaken) begin
               if (txValid) begin
                  next_r.dataOut = txData;
                  next_r.last    = txLast;
                  next_r.txTaken = 1'b1;
               end else begin
                  // underrun ends the transfer rather than send stale data
                  next_r.stp     = 1'b1;
                  next_r.dataOut = BUS_IDLE;
                  next_r.st      = L_STOP;
               end
            end
         end
         L_STOP: begin
            next_r.stp = 1'b0;
            next_r.st  = L_IDLE;
         end
         L_SLEEP: begin
            // next carries nothing here and is not looked at
            next_r.dataOe = 1'b0;
            if (wakeReq) begin
               next_r.stp = 1'b1;
               next_r.st  = L_WAKE;
            end
         end
         L_WAKE: begin
            if (!dirSync) begin
               next_r.stp    = 1'b0;
               next_r.asleep = 1'b0;
               next_r.st     = L_IDLE;
            end
         end
         default: begin
            next_r.st = L_IDLE;
         end
      endcase
   end

   always_ff @(posedge bus.clk or negedge rst_n) begin
      if (!rst_n) begin
         r         <= '0;
         r.st      <= L_IDLE;
         r.prevDir <= RST_LINK_DIR;
      end else begin
         r <= next_r;
      end
   end

   assign bus.stp       = r.stp;
   assign bus.linkData  = r.dataOut;
   assign bus.linkOe    = r.dataOe;
   assign txTaken       = r.txTaken;
   assign rxByte        = r.rxByte;
   assign rxDataValid   = r.rxDataValid;
   assign rxStatusValid = r.rxStatusValid;
   assign asleep        = r.asleep;
endmodule

// File: tb/upbs_bus_props.sv
// concurrent checks on the ulpi bus between the two ends
`timescale 1ns/1ps
module upbs_bus_props (
   // interface clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // control lines
   input wire logic       dir,
   input wire logic       nxt,
   input wire logic       stp,
   // data wire and its enables
   input wire logic       phyOe,
   input wire logic       linkOe,
   input wire logic [7:0] data
);
   logic [1:0] ticks;
   logic       warm;

   // past values mean nothing on the first ticks after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ticks <= 2'h0;
      end else if (ticks != 2'h3) begin
         ticks <= ticks + 2'h1;
      end
   end
   assign warm = ticks == 2'h3;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_no_contention: assert property (!(phyOe && linkOe))
      else $error("both ends drive the data bus");
   a_turn_quiet: assert property (
      warm && $changed(dir) |-> !phyOe && !nxt)
      else $error("transceiver active in a turnaround cycle");
   a_rx_data_driven: assert property (
      warm && dir && nxt |-> phyOe && $past(dir))
      else $error("data flagged without a driven byte");
   a_listen_low: assert property (
      warm && !dir && !$past(dir) |-> !phyOe)
      else $error("transceiver drives bus while direction low");
   a_cmd_holds: assert property (
      warm && !dir && !$past(dir) && linkOe && !stp &&
      $past(data) != 8'h00 && !$past(nxt) |-> data == $past(data))
      else $error("transmit byte changed before next");
   a_stop_pulse: assert property (
      warm && $rose(stp) && !dir |-> data == 8'h00 ##1 !stp)
      else $error("stop after last byte not a clean single pulse");
   a_stop_release: assert property (
      warm && stp && dir && phyOe |-> ##[1:8] !dir)
      else $error("direction not released after stop");
   a_link_yields: assert property (
      warm && $rose(dir) |=> !linkOe)
      else $error("link still drives after direction rose");
   a_next_byte: assert property (
      warm && !dir && !$past(dir) && nxt && linkOe |=> linkOe || stp)
      else $error("link gave no byte after next");
endmodule

// File: tb/ulpi_phy_bus_signaling_tb.sv
// bench joining transceiver and link ends over the ulpi bus
`timescale 1ns/1ps
module ulpi_phy_bus_signaling_tb
   import upbs_pkg::*;
;
   logic       sys_clk = 1'b0;
   logic       rst_n, rxValid, rxActive, rxTaken, statusChange;
   logic       regRdValid, txStrobe, txEnd, lpReq, lowPower;
   logic       txValid, txLast, txTaken, rxDataValid, rxStatusValid;
   logic       abortReq, sleepReq, wakeReq, asleep;
   logic [7:0] rxData, lineStatus, regRdData, txByte, txData, rxByte;
   logic [7:0] txQ[$], rxQ[$], stQ[$];
   int         n_mismatch = 0, n_compared = 0, nCycle = 0, nTxEnd = 0;
   int         nRxTaken = 0;

   upbs_ulpi_if bus ();
   upbs_phy upbs_phy_i (.sys_clk, .rst_n, .bus(bus.phy), .rxValid, .rxData,
      .rxActive, .rxTaken, .lineStatus, .statusChange, .regRdValid,
      .regRdData, .txByte, .txStrobe, .txEnd, .lpReq, .lowPower);
   upbs_link upbs_link_i (.rst_n, .bus(bus.link), .txValid, .txData, .txLast,
      .txTaken, .rxByte, .rxDataValid, .rxStatusValid, .abortReq, .sleepReq,
      .wakeReq, .asleep);
   upbs_bus_props upbs_bus_props_i (.clk(bus.clk), .rst_n(rst_n),
      .dir(bus.dir), .nxt(bus.nxt), .stp(bus.stp), .phyOe(bus.phyOe),
      .linkOe(bus.linkOe), .data(bus.data));

   always #(SYS_CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

   // pulses last one cycle, so they are queued where they are seen
   always @(posedge sys_clk) begin
      if (txStrobe === 1'b1) txQ.push_back(txByte);
      if (txEnd === 1'b1) nTxEnd++;
      if (rxTaken === 1'b1) nRxTaken++;
      nCycle++;
      if (nCycle == 30000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   always @(posedge bus.clk) begin
      if (rxDataValid === 1'b1) rxQ.push_back(rxByte);
      if (rxStatusValid === 1'b1) stQ.push_back(rxByte);
   end

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic expect_q(ref logic [7:0] q[$], input logic [7:0] exp);
      for (int k = 0; k < 300 && q.size() == 0; k++) @(posedge sys_clk);
      chk_bit(q.size() != 0, 1'b1);
      if (q.size() != 0) chk_byte(q.pop_front(), exp);
   endtask
   // bounded wait; cross-domain flags settle within a few bus cycles
   task automatic til(ref logic s, input logic v);
      for (int k = 0; k < 500 && s !== v; k++) @(posedge sys_clk);
   endtask
   task automatic link_send(input logic [7:0] b, input logic last);
      txValid <= 1'b1;
      txData <= b;
      txLast <= last;
      @(posedge bus.clk);
      for (int k = 0; k < 40 && txTaken !== 1'b1; k++) @(posedge bus.clk);
   endtask
   task automatic phy_give(input logic [7:0] b);
      rxValid <= 1'b1;
      rxActive <= 1'b1;
      rxData <= b;
      @(posedge sys_clk);
      for (int k = 0; k < 60 && rxTaken !== 1'b1; k++) @(posedge sys_clk);
      rxValid <= 1'b0;
      // one edge low, so a following call never re-drives it at once
      @(posedge sys_clk);
   endtask

   task automatic t_powerup();
      real t0;
      repeat (100) @(posedge sys_clk);
      chk_bit(bus.dir, 1'b1);
      expect_q(stQ, lineStatus);
      til(bus.dir, 1'b0);
      chk_bit(bus.dir, 1'b0);
      @(posedge bus.clk);
      t0 = $realtime;
      @(posedge bus.clk);
      chk_byte(8'($rtoi($realtime - t0)), 8'(ULPI_CLK_DIV * SYS_CLK_PERIOD_NS));
   endtask
   task automatic t_tx();
      @(posedge bus.clk);
      link_send(8'h00, 1'b1);
      chk_bit(txQ.size() == 0, 1'b1);
      link_send(8'h43, 1'b0);
      link_send(8'ha5, 1'b0);
      link_send(8'h5a, 1'b1);
      txValid <= 1'b0;
      repeat (10) @(posedge bus.clk);
      expect_q(txQ, 8'h43);
      expect_q(txQ, 8'ha5);
      expect_q(txQ, 8'h5a);
      chk_bit(nTxEnd == 1, 1'b1);
   endtask
   task automatic t_rx();
      @(posedge sys_clk);
      phy_give(8'h3c);
      phy_give(8'hc3);
      rxActive <= 1'b0;
      expect_q(rxQ, 8'h3c);
      expect_q(rxQ, 8'hc3);
      chk_bit(nRxTaken == 2, 1'b1);
      repeat (20) @(posedge sys_clk);
      chk_bit(rxQ.size() == 0, 1'b1);
      stQ.delete();
   endtask
   task automatic t_status();
      @(posedge sys_clk);
      lineStatus <= 8'h2d;
      statusChange <= 1'b1;
      @(posedge sys_clk);
      statusChange <= 1'b0;
      expect_q(stQ, 8'h2d);
      regRdData <= 8'h96;
      regRdValid <= 1'b1;
      @(posedge sys_clk);
      regRdValid <= 1'b0;
      expect_q(stQ, 8'h96);
      chk_bit(rxQ.size() == 0, 1'b1);
   endtask
   task automatic t_abort();
      @(posedge sys_clk);
      rxActive <= 1'b1;
      til(bus.dir, 1'b1);
      @(posedge bus.clk);
      abortReq <= 1'b1;
      til(bus.dir, 1'b0);
      chk_bit(bus.dir, 1'b0);
      @(posedge sys_clk);
      rxActive <= 1'b0;
      abortReq <= 1'b0;
      repeat (30) @(posedge sys_clk);
      stQ.delete();
   endtask
   task automatic t_lowpower();
      @(posedge sys_clk);
      lpReq <= 1'b1;
      til(lowPower, 1'b1);
      lpReq <= 1'b0;
      @(posedge bus.clk);
      sleepReq <= 1'b1;
      til(asleep, 1'b1);
      repeat (20) @(posedge sys_clk);
      chk_bit(bus.dir, 1'b1);
      chk_byte({6'h00, bus.data[1:0]}, {6'h00, lineStatus[1:0]});
      stQ.delete();
      @(posedge bus.clk);
      wakeReq <= 1'b1;
      sleepReq <= 1'b0;
      til(lowPower, 1'b0);
      chk_bit(lowPower, 1'b0);
      til(bus.dir, 1'b0);
      // link leaves wake only after its re-timed direction reads low
      til(asleep, 1'b0);
      @(posedge bus.clk);
      wakeReq <= 1'b0;
      chk_bit(asleep, 1'b0);
      expect_q(stQ, lineStatus);
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      {rxValid, rxActive, statusChange, regRdValid, lpReq} = 5'h00;
      {txValid, txLast, abortReq, sleepReq, wakeReq} = 5'h00;
      {rxData, regRdData, txData} = 24'h000000;
      lineStatus = 8'h41;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_powerup();
      t_tx();
      t_rx();
      t_status();
      t_abort();
      t_lowpower();
      end_of_test();
   end
endmodule
